// *** src/dmaf_pkg.sv ***
package dmaf_pkg;
   // register map, byte addresses
   localparam logic [7:0] OFS_SRC = 8'h00;
   localparam logic [7:0] OFS_DST = 8'h04;
   localparam logic [7:0] OFS_CNT = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;
   localparam logic [7:0] OFS_RSEL = 8'h10;
   localparam logic [7:0] OFS_VEC = 8'h14;
   localparam logic [7:0] OFS_GLB = 8'h40;
   localparam int CH_LSB = 5;
   localparam logic [7:0] OFS_IN_CH = 8'h1f;
   // chan_ctrl_reg fields
   localparam int CC_CHAN_EN = 0;
   localparam int CC_DONE = 1;
   localparam int CC_END_IE = 2;
   localparam int CC_BURST = 3;
   localparam int CC_EDGE = 4;
   localparam int CC_POL_HI = 5;
   localparam int CC_ACK_DIR = 6;
   localparam int CC_SINGLE = 7;
   localparam int CC_AUTO = 8;
   localparam int CC_SIZE = 9;
   localparam int CC_W = 11;
   // global_ctrl_reg fields
   localparam int GC_EN = 0;
   localparam int GC_NMI = 1;
   localparam int GC_AE = 2;
   localparam int GC_W = 3;
   localparam int NPERIPH = 14;
   localparam logic [4:0] SEL_EXT = 5'h1e;
   localparam logic [4:0] SEL_NONE = 5'h1f;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {ENG_IDLE = 2'b00, ENG_READ = 2'b01, ENG_WRITE = 2'b10} dmaf_eng_type;
   // source code to requester line; peripheral vector index order is fixed
   function automatic logic [4:0] dmafReqLine(input logic [4:0] code);
      unique case (code)
         5'h00: dmafReqLine = SEL_EXT;
         5'h05: dmafReqLine = 5'h00;
         5'h06: dmafReqLine = 5'h01;
         5'h09: dmafReqLine = 5'h02;
         5'h0a: dmafReqLine = 5'h03;
         5'h0c: dmafReqLine = 5'h04;
         5'h0d: dmafReqLine = 5'h05;
         5'h0e: dmafReqLine = 5'h06;
         5'h0f: dmafReqLine = 5'h07;
         5'h11: dmafReqLine = 5'h08;
         5'h12: dmafReqLine = 5'h09;
         5'h15: dmafReqLine = 5'h0a;
         5'h16: dmafReqLine = 5'h0b;
         5'h19: dmafReqLine = 5'h0c;
         5'h1a: dmafReqLine = 5'h0d;
         default: dmafReqLine = SEL_NONE;
      endcase
   endfunction
   function automatic logic [31:0] dmafUnitBytes(input logic [1:0] size);
      unique case (size)
         2'b00: dmafUnitBytes = 32'h0000_0001;
         2'b01: dmafUnitBytes = 32'h0000_0002;
         2'b10: dmafUnitBytes = 32'h0000_0004;
         2'b11: dmafUnitBytes = 32'h0000_0010;
      endcase
   endfunction
endpackage

// *** src/dmaf_core.sv ***
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module dmaf_core
   import dmaf_pkg::*;
#(
   parameter int NCH = 2,
   parameter int CNT_W = 24
)(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NCH-1:0] extXferReqN,
   output logic [NCH-1:0] extXferAckN,
   input wire logic nmiPin,
   input wire logic [1:0] asyncRxFullReq,
   input wire logic [1:0] asyncTxEmptyReq,
   input wire logic timerCmpAReq,
   input wire logic timerCmpBReq,
   input wire logic timerCmpCReq,
   input wire logic timerCmpDReq,
   input wire logic [2:0] syncRxFullReq,
   input wire logic [2:0] syncTxEmptyReq,
   output logic [NPERIPH-1:0] periphReqClr,
   output logic memReq,
   output logic memWrite,
   output logic [31:0] memAddr,
   output logic [1:0] memSize,
   output logic [31:0] memWdata,
   input wire logic [31:0] memRdata,
   input wire logic memDone,
   input wire logic memAddrErr,
   output logic [NCH-1:0] endOfCountIrq
);
   localparam int CW = $clog2(NCH > 1 ? NCH : 2);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [NCH-1:0] reqMetaQ, reqSyncQ, reqPrevQ;
   logic nmiMetaQ, nmiSyncQ, nmiPrevQ;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         reqMetaQ <= '1;
         reqSyncQ <= '1;
         reqPrevQ <= '1;
         nmiMetaQ <= 1'b0;
         nmiSyncQ <= 1'b0;
         nmiPrevQ <= 1'b0;
      end
      else
      begin
         reqMetaQ <= extXferReqN;
         reqSyncQ <= reqMetaQ;
         reqPrevQ <= reqSyncQ;
         nmiMetaQ <= nmiPin;
         nmiSyncQ <= nmiMetaQ;
         nmiPrevQ <= nmiSyncQ;
      end
   end

   // ****************************************
   // state
   // ****************************************
   logic [31:0] srcQ [NCH], srcD [NCH];
   logic [31:0] dstQ [NCH], dstD [NCH];
   logic [CNT_W-1:0] cntQ [NCH], cntD [NCH];
   logic [CC_W-1:0] ctrlQ [NCH], ctrlD [NCH];
   logic [4:0] rselQ [NCH], rselD [NCH];
   logic [7:0] vecQ [NCH], vecD [NCH];
   logic [GC_W-1:0] glbQ, glbD;
   logic nmiSeenQ, nmiSeenD, aeSeenQ, aeSeenD;
   logic [NCH-1:0] edgePendQ, edgePendD, irqQ, irqD, ackNQ, ackND;
   dmaf_eng_type engQ, engD;
   logic [CW-1:0] chQ, chD;
   logic [31:0] bufQ, bufD, addrQ, addrD;
   logic [NPERIPH-1:0] clrQ, clrD;
   logic awHeldQ, awHeldD, wHeldQ, wHeldD, bvalidQ, bvalidD, awrdyQ, awrdyD, wrdyQ, wrdyD;
   logic [7:0] awAddrQ, awAddrD;
   logic [31:0] wDataQ, wDataD, rdataQ, rdataD;
   logic [3:0] wStrbQ, wStrbD;
   logic [1:0] brespQ, brespD, rrespQ, rrespD;
   logic rvalidQ, rvalidD, arrdyQ, arrdyD;

   // ****************************************
   // request qualification
   // ****************************************
   logic [NPERIPH-1:0] periphLines;
   logic [NCH-1:0] canRun, pending, extAct, extEdge;
   logic [4:0] lineSel [NCH];
   always_comb
   begin
      periphLines = {syncTxEmptyReq[2], syncRxFullReq[2], syncTxEmptyReq[1], syncRxFullReq[1],
                     syncTxEmptyReq[0], syncRxFullReq[0], timerCmpDReq, timerCmpCReq,
                     timerCmpBReq, timerCmpAReq, asyncTxEmptyReq[1], asyncRxFullReq[1],
                     asyncTxEmptyReq[0], asyncRxFullReq[0]};
      for (int c = 0; c < NCH; c++)
      begin
         canRun[c] = ctrlQ[c][CC_CHAN_EN] && glbQ[GC_EN] && !ctrlQ[c][CC_DONE]
                     && !glbQ[GC_NMI] && !glbQ[GC_AE];
         extAct[c] = ctrlQ[c][CC_POL_HI] ? reqSyncQ[c] : !reqSyncQ[c];
         extEdge[c] = ctrlQ[c][CC_POL_HI] ? (reqSyncQ[c] && !reqPrevQ[c])
                                         : (!reqSyncQ[c] && reqPrevQ[c]);
         lineSel[c] = dmafReqLine(rselQ[c]);
         if (ctrlQ[c][CC_AUTO])
            pending[c] = 1'b1;
         else if (lineSel[c] == SEL_EXT)
            pending[c] = ctrlQ[c][CC_EDGE] ? edgePendQ[c] : extAct[c];
         else if (lineSel[c] == SEL_NONE)
            pending[c] = 1'b0;
         else
            pending[c] = periphLines[lineSel[c][3:0]];
      end
   end

   // ****************************************
   // bus slave, registers and transfer engine
   // ****************************************
   function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      for (int b = 0; b < 4; b++)
         if (strb[b])
            old[8*b +: 8] = nw[8*b +: 8];
      return old;
   endfunction

   logic [31:0] wv, rv;
   logic [CW-1:0] wch, rch, sc;
   logic startOk, doWrite, lastUnit, keepBurst;
   always_comb
   begin
      srcD = srcQ; dstD = dstQ; cntD = cntQ; ctrlD = ctrlQ; rselD = rselQ; vecD = vecQ;
      glbD = glbQ; nmiSeenD = nmiSeenQ; aeSeenD = aeSeenQ;
      engD = engQ; chD = chQ; bufD = bufQ; addrD = addrQ; clrD = '0;
      awHeldD = awHeldQ; wHeldD = wHeldQ; awAddrD = awAddrQ; wDataD = wDataQ; wStrbD = wStrbQ;
      bvalidD = bvalidQ; brespD = brespQ; rvalidD = rvalidQ; rdataD = rdataQ; rrespD = rrespQ;
      wv = '0; rv = '0; startOk = 1'b0; sc = '0; lastUnit = 1'b0; keepBurst = 1'b0;
      wch = CW'(awAddrQ >> CH_LSB);
      rch = CW'(s_axi_araddr >> CH_LSB);
      // write channel: address and data taken in either order, response after both
      if (s_axi_awvalid && awrdyQ)
      begin
         awHeldD = 1'b1;
         awAddrD = s_axi_awaddr;
      end
      if (s_axi_wvalid && wrdyQ)
      begin
         wHeldD = 1'b1;
         wDataD = s_axi_wdata;
         wStrbD = s_axi_wstrb;
      end
      if (bvalidQ && s_axi_bready)
         bvalidD = 1'b0;
      doWrite = awHeldQ && wHeldQ && !bvalidQ;
      if (doWrite)
      begin
         awHeldD = 1'b0;
         wHeldD = 1'b0;
         bvalidD = 1'b1;
         brespD = RESP_OKAY;
         if (awAddrQ == OFS_GLB)
         begin
            wv = mergeStrb(32'(glbQ), wDataQ, wStrbQ);
            glbD[GC_EN] = wv[GC_EN];
            if (!wv[GC_NMI] && nmiSeenQ)
               glbD[GC_NMI] = 1'b0;
            if (!wv[GC_AE] && aeSeenQ)
               glbD[GC_AE] = 1'b0;
         end
         else if ((awAddrQ >> CH_LSB) < NCH)
         begin
            unique case (awAddrQ & OFS_IN_CH)
               OFS_SRC: srcD[wch] = mergeStrb(srcQ[wch], wDataQ, wStrbQ);
               OFS_DST: dstD[wch] = mergeStrb(dstQ[wch], wDataQ, wStrbQ);
               OFS_CNT: cntD[wch] = CNT_W'(mergeStrb(32'(cntQ[wch]), wDataQ, wStrbQ));
               OFS_CTRL:
               begin
                  wv = mergeStrb(32'(ctrlQ[wch]), wDataQ, wStrbQ);
                  // done flag only clears by writing zero; writing one keeps it
                  ctrlD[wch] = CC_W'(wv) & ~(CC_W'(1) << CC_DONE) |
                               (ctrlQ[wch] & wv[CC_W-1:0] & (CC_W'(1) << CC_DONE));
               end
               OFS_RSEL: rselD[wch] = 5'(mergeStrb(32'(rselQ[wch]), wDataQ, wStrbQ));
               OFS_VEC: vecD[wch] = 8'(mergeStrb(32'(vecQ[wch]), wDataQ, wStrbQ));
               default: brespD = RESP_SLVERR;
            endcase
         end
         else
            brespD = RESP_SLVERR;
      end
      // read channel
      if (rvalidQ && s_axi_rready)
         rvalidD = 1'b0;
      if (s_axi_arvalid && arrdyQ)
      begin
         rvalidD = 1'b1;
         rrespD = RESP_OKAY;
         if (s_axi_araddr == OFS_GLB)
         begin
            rv = 32'(glbQ);
            nmiSeenD = glbQ[GC_NMI];
            aeSeenD = glbQ[GC_AE];
         end
         else if ((s_axi_araddr >> CH_LSB) < NCH)
         begin
            unique case (s_axi_araddr & OFS_IN_CH)
               OFS_SRC: rv = srcQ[rch];
               OFS_DST: rv = dstQ[rch];
               OFS_CNT: rv = 32'(cntQ[rch]);
               OFS_CTRL: rv = 32'(ctrlQ[rch]);
               OFS_RSEL: rv = 32'(rselQ[rch]);
               OFS_VEC: rv = 32'(vecQ[rch]);
               default: rrespD = RESP_SLVERR;
            endcase
         end
         else
            rrespD = RESP_SLVERR;
         rdataD = rv;
      end
      // request pick: lower channel first, arbitration beyond that is not modelled
      for (int c = NCH - 1; c >= 0; c--)
         if (canRun[c] && pending[c])
         begin
            startOk = 1'b1;
            sc = CW'(c);
         end
      unique case (engQ)
         ENG_IDLE:
            if (startOk)
            begin
               chD = sc;
               // dual, or single memory-to-device, opens with a read of the source
               if (ctrlQ[sc][CC_SINGLE] && ctrlQ[sc][CC_ACK_DIR])
                  engD = ENG_WRITE;
               else
                  engD = ENG_READ;
               addrD = (engD == ENG_READ) ? srcQ[sc] : dstQ[sc];
               if (!ctrlQ[sc][CC_AUTO] && lineSel[sc] != SEL_EXT)
                  clrD[lineSel[sc][3:0]] = 1'b1;
            end
         ENG_READ:
            if (memDone)
            begin
               bufD = memRdata;
               if (memAddrErr)
                  engD = ENG_IDLE;
               else if (ctrlQ[chQ][CC_SINGLE])
                  lastUnit = 1'b1;
               else
               begin
                  engD = ENG_WRITE;
                  addrD = dstQ[chQ];
               end
            end
         ENG_WRITE:
            if (memDone)
            begin
               if (memAddrErr)
                  engD = ENG_IDLE;
               else
                  lastUnit = 1'b1;
            end
      endcase
      if (lastUnit)
      begin
         cntD[chQ] = cntQ[chQ] - CNT_W'(1);
         srcD[chQ] = srcQ[chQ] + dmafUnitBytes(ctrlQ[chQ][CC_SIZE +: 2]);
         dstD[chQ] = dstQ[chQ] + dmafUnitBytes(ctrlQ[chQ][CC_SIZE +: 2]);
         engD = ENG_IDLE;
         if (cntQ[chQ] == CNT_W'(1))
            ctrlD[chQ][CC_DONE] = 1'b1;
         else
            // burst keeps the bus for auto or edge requests; level and cycle-steal release it
            keepBurst = canRun[chQ] && ctrlQ[chQ][CC_BURST] && (ctrlQ[chQ][CC_AUTO] ||
                        (lineSel[chQ] == SEL_EXT && ctrlQ[chQ][CC_EDGE]));
         if (keepBurst)
         begin
            engD = (ctrlQ[chQ][CC_SINGLE] && ctrlQ[chQ][CC_ACK_DIR]) ? ENG_WRITE : ENG_READ;
            addrD = (engD == ENG_READ) ? srcD[chQ] : dstD[chQ];
         end
      end
      if ((engQ != ENG_IDLE) && memDone && memAddrErr)
         glbD[GC_AE] = 1'b1;
      if (nmiSyncQ && !nmiPrevQ)
         glbD[GC_NMI] = 1'b1;
      for (int c = 0; c < NCH; c++)
      begin
         // edges only pend while the channel is enabled in edge mode; a pending edge drops only when the channel starts or leaves that mode
         edgePendD[c] = ctrlQ[c][CC_CHAN_EN] && ctrlQ[c][CC_EDGE] && (extEdge[c] ||
                        (edgePendQ[c] && !(engQ == ENG_IDLE && startOk && sc == CW'(c))));
         irqD[c] = ctrlD[c][CC_DONE] && ctrlD[c][CC_END_IE];
         // single addressing acknowledges every cycle, dual only the chosen one
         ackND[c] = !(engD != ENG_IDLE && chD == CW'(c) && (ctrlD[c][CC_SINGLE] ||
                    ((engD == ENG_WRITE) == ctrlD[c][CC_ACK_DIR])));
      end
      awrdyD = !awHeldD && !bvalidD;
      wrdyD = !wHeldD && !bvalidD;
      arrdyD = !rvalidD;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         srcQ <= '{default: '0}; dstQ <= '{default: '0}; cntQ <= '{default: '0};
         ctrlQ <= '{default: '0}; rselQ <= '{default: '0}; vecQ <= '{default: '0};
         glbQ <= '0; nmiSeenQ <= 1'b0; aeSeenQ <= 1'b0;
         edgePendQ <= '0; irqQ <= '0; ackNQ <= '1;
         engQ <= ENG_IDLE; chQ <= '0; bufQ <= '0; addrQ <= '0; clrQ <= '0;
         awHeldQ <= 1'b0; wHeldQ <= 1'b0; awAddrQ <= '0; wDataQ <= '0; wStrbQ <= '0;
         bvalidQ <= 1'b0; brespQ <= RESP_OKAY; awrdyQ <= 1'b0; wrdyQ <= 1'b0;
         rvalidQ <= 1'b0; rdataQ <= '0; rrespQ <= RESP_OKAY; arrdyQ <= 1'b0;
      end
      else
      begin
         srcQ <= srcD; dstQ <= dstD; cntQ <= cntD;
         ctrlQ <= ctrlD; rselQ <= rselD; vecQ <= vecD;
         glbQ <= glbD; nmiSeenQ <= nmiSeenD; aeSeenQ <= aeSeenD;
         edgePendQ <= edgePendD; irqQ <= irqD; ackNQ <= ackND;
         engQ <= engD; chQ <= chD; bufQ <= bufD; addrQ <= addrD; clrQ <= clrD;
         awHeldQ <= awHeldD; wHeldQ <= wHeldD; awAddrQ <= awAddrD; wDataQ <= wDataD;
         wStrbQ <= wStrbD; bvalidQ <= bvalidD; brespQ <= brespD; awrdyQ <= awrdyD;
         wrdyQ <= wrdyD; rvalidQ <= rvalidD; rdataQ <= rdataD; rrespQ <= rrespD;
         arrdyQ <= arrdyD;
      end
   end

   // memory request fields are flops or decoded straight from flops of the engine
   logic [1:0] sizeQ;
   logic writeQ;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sizeQ <= '0;
         writeQ <= 1'b0;
      end
      else
      begin
         sizeQ <= ctrlD[chD][CC_SIZE +: 2];
         writeQ <= (engD == ENG_WRITE);
      end
   end

   assign s_axi_awready = awrdyQ;
   assign s_axi_wready = wrdyQ;
   assign s_axi_bvalid = bvalidQ;
   assign s_axi_bresp = brespQ;
   assign s_axi_arready = arrdyQ;
   assign s_axi_rvalid = rvalidQ;
   assign s_axi_rdata = rdataQ;
   assign s_axi_rresp = rrespQ;
   assign extXferAckN = ackNQ;
   assign periphReqClr = clrQ;
   assign memReq = (engQ != ENG_IDLE);
   assign memWrite = writeQ;
   assign memAddr = addrQ;
   assign memSize = sizeQ;
   assign memWdata = bufQ;
   assign endOfCountIrq = irqQ;
endmodule

// *** bench/dmaf_chk.sv ***
`timescale 1ns/1ps
// ****
// protocol and transfer checks
// ****
module dmaf_chk
   import dmaf_pkg::*;
#(
   parameter int NCH = 2
)(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic [31:0] memAddr,
   input wire logic memDone,
   input wire logic [NCH-1:0] extXferAckN
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   sequence s_memWait;
      memReq && !memDone;
   endsequence
   sequence s_memHeld;
      memReq && $stable(memAddr) && $stable(memWrite);
   endsequence
   property p_memHold; s_memWait |=> s_memHeld; endproperty
   a_memHold: assert property (p_memHold) else $error("access changed before done");
   property p_ackInAccess; !extXferAckN[0] |-> memReq; endproperty
   a_ackInAccess: assert property (p_ackInAccess) else $error("ack outside access");
   property p_rLat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rLat: assert property (p_rLat) else $error("read answer late");
   property p_arBlock; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arBlock: assert property (p_arBlock) else $error("read taken while answering");
   property p_awBlock; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_awBlock: assert property (p_awBlock) else $error("write taken while answering");
   property p_errZero; s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
   a_errZero: assert property (p_errZero) else $error("error read carries data");
   property p_bOnce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bOnce: assert property (p_bOnce) else $error("write answer repeated");
   property p_rOnce; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rOnce: assert property (p_rOnce) else $error("read answer repeated");
endmodule
bind dmaf_core dmaf_chk #(.NCH(NCH)) i_chk (.*);

// *** bench/dmaf_mem_model.sv ***
`timescale 1ns/1ps
// ****
// memory side of the engine
// ****
module dmaf_mem_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic memReq,
   input wire logic [31:0] memAddr,
   input wire logic slow,
   input wire logic errOn,
   output logic [31:0] memRdata,
   output logic memDone,
   output logic memAddrErr
);
   int waitQ;
   // data is the inverted address, so every moved word is traceable
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         memDone <= 1'b0;
         memAddrErr <= 1'b0;
         memRdata <= 32'h0;
         waitQ <= 0;
      end
      else if (memReq && !memDone && waitQ == 0)
      begin
         memDone <= 1'b1;
         memAddrErr <= errOn;
         memRdata <= ~memAddr;
         waitQ <= slow ? $urandom_range(4, 1) : 0;
      end
      else
      begin
         memDone <= 1'b0;
         memAddrErr <= 1'b0;
         // no stale data between accesses
         memRdata <= $urandom;
         if (memReq && waitQ > 0)
            waitQ <= waitQ - 1;
      end
   end
endmodule

// *** bench/dmaf_core_tb.sv ***
`timescale 1ns/1ps
// ****
// transfers driven through the register bus
// ****
module dmaf_core_tb;
   import dmaf_pkg::*;
   localparam logic [31:0] AUTO_L = (32'h1 << CC_CHAN_EN) | (32'h1 << CC_AUTO) | (32'h2 << CC_SIZE);
   localparam logic [31:0] EXT_L = (32'h1 << CC_CHAN_EN) | (32'h2 << CC_SIZE);
   logic ref_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, nmiPin, memReq;
   logic memWrite, memDone, memAddrErr, timerCmpAReq, timerCmpBReq, timerCmpCReq, timerCmpDReq;
   logic slow, errOn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, memAddr, memWdata, memRdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, asyncRxFullReq, asyncTxEmptyReq, memSize;
   logic [1:0] extXferReqN, extXferAckN, endOfCountIrq;
   logic [2:0] syncRxFullReq, syncTxEmptyReq;
   logic [13:0] pr, periphReqClr;
   int fails = 0;
   int checks_done = 0;
   int nWr = 0;
   logic [31:0] lastRd;
   assign asyncRxFullReq = {pr[2], pr[0]};
   assign asyncTxEmptyReq = {pr[3], pr[1]};
   assign {timerCmpDReq, timerCmpCReq, timerCmpBReq, timerCmpAReq} = pr[7:4];
   assign syncRxFullReq = {pr[12], pr[10], pr[8]};
   assign syncTxEmptyReq = {pr[13], pr[11], pr[9]};
   dmaf_core i_dut (.*);
   dmaf_mem_model i_mem (.*);
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (memReq === 1'b1 && memDone === 1'b1 && memWrite === 1'b1)
         nWr <= nWr + 1;
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // dual transfers write what they read; the model returns the inverted address
   always @(posedge ref_clk)
      if (memReq === 1'b1 && memDone === 1'b1)
      begin
         if (memWrite === 1'b0)
            lastRd <= memAddr;
         else
            chk(memWdata, ~lastRd);
      end
   task automatic giveUp();
      fails++;
      conclude();
   endtask
   // one word per call; each channel released as soon as it is taken
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         n++;
      end
      while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      if (n >= 50) giveUp();
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic [1:0] r;
      bus(1'b1, a, d, x, r);
   endtask
   task automatic rdReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      logic [1:0] r;
      bus(1'b0, a, 32'h0, x, r);
      chk(x & m, e);
   endtask
   task automatic prog(input logic [7:0] b, input logic [31:0] cnt, input logic [31:0] ctl,
      input logic [4:0] rs);
      wrReg(b + OFS_SRC, 32'h1000);
      wrReg(b + OFS_DST, 32'h8000);
      wrReg(b + OFS_CNT, cnt);
      wrReg(b + OFS_RSEL, 32'(rs));
      wrReg(b + OFS_CTRL, ctl);
   endtask
   task automatic waitDone(input logic [7:0] b);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      do
      begin
         bus(1'b0, b + OFS_CTRL, 32'h0, d, r);
         n++;
      end
      while (d[CC_DONE] !== 1'b1 && n < 200);
      if (n >= 200) giveUp();
   endtask
   initial
   begin
      logic [31:0] d;
      logic [1:0] r;
      logic [4:0] codes [14];
      int n, w0;
      codes = '{5'h05, 5'h06, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h15,
         5'h16, 5'h19, 5'h1a};
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {nmiPin, slow, errOn, pr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      extXferReqN = 2'b11;
      n = $urandom(32'h028e5c17);
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rdReg(OFS_CTRL, 32'hffffffff, 32'h0);
      rdReg(OFS_GLB, 32'hffffffff, 32'h0);
      bus(1'b0, 8'h18, 32'h0, d, r);
      chk({d[29:0], r}, {30'h0, RESP_SLVERR});
      bus(1'b1, 8'h38, 32'hffffffff, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      $display("test reset and map done");
      wrReg(OFS_GLB, 32'h1);
      for (int ie = 0; ie < 2; ie++)
      begin
         n = $urandom_range(6, 1);
         w0 = nWr;
         prog(8'h00, n, AUTO_L | (32'(ie) << CC_END_IE), 5'($urandom));
         waitDone(8'h00);
         rdReg(OFS_CNT, 32'hffffffff, 32'h0);
         rdReg(OFS_SRC, 32'hffffffff, 32'h1000 + 4 * n);
         chk(nWr - w0, n);
         chk(32'(endOfCountIrq[0]), 32'(ie));
         wrReg(OFS_CTRL, 32'h0);
      end
      $display("test auto request done");
      slow <= 1'b1;
      prog(8'h00, 32'd60, AUTO_L, 5'h00);
      repeat (60) @(posedge ref_clk);
      wrReg(OFS_GLB, 32'h0);
      repeat (30) @(posedge ref_clk);
      bus(1'b0, OFS_CNT, 32'h0, d, r);
      chk(32'(d < 32'd60 && d != 32'd0), 32'h1);
      repeat (60) @(posedge ref_clk);
      rdReg(OFS_CNT, 32'hffffffff, d);
      slow <= 1'b0;
      wrReg(OFS_CTRL, 32'h0);
      wrReg(OFS_GLB, 32'h1);
      nmiPin <= 1'b1;
      repeat (5) @(posedge ref_clk);
      nmiPin <= 1'b0;
      prog(8'h00, 32'd2, AUTO_L, 5'h00);
      repeat (40) @(posedge ref_clk);
      rdReg(OFS_CNT, 32'hffffffff, 32'd2);
      rdReg(OFS_GLB, 32'hffffffff, 32'h3);
      wrReg(OFS_GLB, 32'h1);
      waitDone(8'h00);
      wrReg(OFS_CTRL, 32'h0);
      errOn <= 1'b1;
      prog(8'h00, 32'd3, AUTO_L, 5'h00);
      repeat (40) @(posedge ref_clk);
      errOn <= 1'b0;
      rdReg(OFS_GLB, 32'hffffffff, 32'h5);
      rdReg(OFS_CTRL, 32'h1 << CC_DONE, 32'h0);
      wrReg(OFS_CTRL, 32'h0);
      wrReg(OFS_GLB, 32'h1);
      rdReg(OFS_GLB, 32'hffffffff, 32'h1);
      $display("test abort and flags done");
      // bit 0 of m picks edge sensing, bit 1 the active-high polarity
      for (int m = 0; m < 4; m++)
      begin
         extXferReqN[0] <= ~m[1];
         repeat (10) @(posedge ref_clk);
         prog(8'h00, 32'd2, EXT_L | (32'(m) << CC_EDGE), 5'h00);
         for (int p = 0; p < 2; p++)
         begin
            extXferReqN[0] <= m[1];
            repeat (40) @(posedge ref_clk);
            extXferReqN[0] <= ~m[1];
            repeat (10) @(posedge ref_clk);
            if (p == 0) rdReg(OFS_CNT, 32'hffffffff, 32'(m[0]));
         end
         waitDone(8'h00);
         wrReg(OFS_CTRL, 32'h0);
      end
      $display("test external request done");
      for (int i = 0; i < 14; i++)
      begin
         prog(8'h20, 32'd1, 32'h1 << CC_CHAN_EN, codes[i]);
         pr[i] <= 1'b1;
         n = 0;
         do
         begin
            @(posedge ref_clk);
            n++;
         end
         while (periphReqClr === 14'h0 && n < 80);
         pr[i] <= 1'b0;
         chk(32'(periphReqClr), 32'h1 << i);
         waitDone(8'h20);
         wrReg(8'h20 + OFS_CTRL, 32'h0);
      end
      $display("test peripheral sources done");
      conclude();
   end
endmodule
